// [src/lec_pkg.sv]
// Shared constants and types for the lane code error counter block
package lec_pkg;

   // Counter geometry: three lane slots, three counters per lane
   localparam int unsigned NUM_LANES = 3;
   localparam int unsigned NUM_KINDS = 3;
   localparam int unsigned NUM_CNT = NUM_LANES * NUM_KINDS;
   localparam int unsigned CNT_W = 8;
   localparam int unsigned FIELD_W = 3;
   localparam int unsigned REG_W = 8;

   // Lane slots inside the packed per-lane arrays
   localparam int unsigned SLOT_LANE0 = 0;
   localparam int unsigned SLOT_LANE6 = 1;
   localparam int unsigned SLOT_LANE7 = 2;

   // Counter selection inside every enable, clear and hold field
   localparam int unsigned SEL_UNEXPECTED_CTRL = 2;
   localparam int unsigned SEL_INVALID_CODE = 1;
   localparam int unsigned SEL_DISPARITY = 0;

   // Terminal count of each error counter
   localparam logic [CNT_W-1:0] CNT_TERMINAL = 8'hFF;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

   // Field positions in the control and hold registers
   localparam int unsigned ENA_LSB = 3;
   localparam int unsigned CLR_LSB = 0;
   localparam int unsigned HOLD_LSB = 0;
   localparam logic [REG_W-1:0] CTRL_MASK = 8'h3F;
   localparam logic [REG_W-1:0] HOLD_MASK = 8'h07;
   localparam logic [REG_W-1:0] CTRL_RESET = 8'h3F;
   localparam logic [REG_W-1:0] HOLD_RESET = 8'h07;

   // Register indices; byte address is four times the index
   localparam int unsigned IDX_W = 12;
   localparam int unsigned IDX_LSB = 2;
   localparam logic [IDX_W-1:0] IDX_LANE0_CTRL = 12'h480;
   localparam logic [IDX_W-1:0] IDX_LANE6_CTRL = 12'h486;
   localparam logic [IDX_W-1:0] IDX_LANE7_CTRL = 12'h487;
   localparam logic [IDX_W-1:0] IDX_LANE0_HOLD = 12'h488;
   localparam logic [IDX_W-1:0] IDX_LANE6_HOLD = 12'h48E;
   localparam logic [IDX_W-1:0] IDX_LANE7_HOLD = 12'h48F;
   localparam logic [IDX_W-1:0] IDX_LANE0_COUNT = 12'h490;
   localparam logic [IDX_W-1:0] IDX_LANE6_COUNT = 12'h491;
   localparam logic [IDX_W-1:0] IDX_LANE7_COUNT = 12'h492;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 12'h4A0;
   localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 12'h4A1;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 12'h4A2;

   // Interrupt register reset values
   localparam logic [NUM_CNT-1:0] IRQ_NONE = 9'h000;

   // AHB-Lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'b0;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // Bus slave phase, one-hot
   typedef enum logic [1:0] {
      PH_IDLE = 2'b01,
      PH_WRITE = 2'b10
   } lec_phase_t;

   // Whole state of the register bank
   typedef struct packed {
      logic rstMeta;
      logic rstSync;
   } lec_rst_t;

   typedef struct packed {
      logic [NUM_LANES-1:0][REG_W-1:0] ctrl;
      logic [NUM_LANES-1:0][REG_W-1:0] hold;
      lec_phase_t phase;
      logic [IDX_W-1:0] wrIdx;
      logic [31:0] rdata;
      logic ready;
      logic resp;
      logic [NUM_CNT-1:0] irqStatus;
      logic [NUM_CNT-1:0] irqEnable;
      logic irq;
   } lec_state_t;

   // State of one error counter
   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic tcEvent;
   } lec_cnt_state_t;

endpackage

// [src/lec_err_counter.sv]
// One eight-bit code error counter with enable, clear and terminal hold
`timescale 1ns/1ns
`default_nettype none

module lec_err_counter (
   input wire logic core_clk,
   input wire logic rstSync_n,
   input wire logic errPulse,
   input wire logic enable,
   input wire logic clear,
   input wire logic hold,
   output logic [lec_pkg::CNT_W-1:0] count,
   output logic tcEvent
);

   // Registered state and its next value
   lec_pkg::lec_cnt_state_t st;
   lec_pkg::lec_cnt_state_t next_st;

   // Next-state logic: clear first, then counting
   always_comb begin
      next_st = st;
      next_st.tcEvent = 1'b0;
      if (clear) begin
         // Counter forced to zero while its clear bit stands
         next_st.count = lec_pkg::CNT_ZERO;
      end else if (enable && errPulse) begin
         // One per detected error, only while enabled
         if (st.count == lec_pkg::CNT_TERMINAL) begin
            if (!hold) begin
               // Unheld counter rolls over and keeps counting
               next_st.count = lec_pkg::CNT_ZERO;
            end
         end else begin
            next_st.count = st.count + lec_pkg::CNT_ONE;
            // Mark the arrival at terminal count
            next_st.tcEvent = (st.count + lec_pkg::CNT_ONE)
               == lec_pkg::CNT_TERMINAL;
         end
      end
      // Held counter stays at terminal count until cleared
   end

   // State register
   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the flip-flops
   assign count = st.count;
   assign tcEvent = st.tcEvent;

endmodule

`default_nettype wire

// [src/lec_top.sv]
// Register bank and counters for per-lane code error counting
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Per-lane enable field [5:3], resets all ones
// - Per-lane clear field [2:0], resets all ones
// - Bit2 control char, bit1 table, bit0 disparity
// - Held counter stops at 0xFF until cleared
// - Unheld counter wraps to zero and continues
// - Lane0 hold field [2:0], reserved zero, resets 0x7
module lec_top (
   input wire logic core_clk,
   input wire logic reset_n,
   // AHB-Lite slave port
   // hsize ignored: word access only
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Error strobes from the lane decoders, same clock domain
   // One error per cycle per high bit
   input wire logic [lec_pkg::FIELD_W-1:0] errLane0,
   input wire logic [lec_pkg::FIELD_W-1:0] errLane6,
   input wire logic [lec_pkg::FIELD_W-1:0] errLane7,
   // Level interrupt
   // High while enabled status is set
   output logic irq
);

   // Block overview
   // Nine 8-bit counters, three per slot
   // Slots hold lanes 0, 6 and 7
   // Control words: enable and clear
   // Hold words: stop or wrap when full
   // Count words: live lane values
   // Full count sets sticky status
   // Status and enable drive one irq
   // Zero wait states, always OKAY
   // Reserved bits read zero
   // No counting while clear is set
   // Writes to read-only words dropped

   // Reset synchroniser state
   // Pin may rise at any time;
   // two flops give a clean release
   lec_pkg::lec_rst_t rs;
   // Reset for all other logic
   logic rstSync_n;

   // Register bank state and its next value
   // One struct, one register process
   lec_pkg::lec_state_t st;
   // Filled by the comb process
   lec_pkg::lec_state_t next_st;

   // Error strobes gathered by lane slot
   // Same order as the field arrays
   logic [lec_pkg::NUM_LANES-1:0][lec_pkg::FIELD_W-1:0] errIn;

   // Counter values and terminal-count events, flat by counter
   // Index is slot times three plus kind
   logic [lec_pkg::NUM_CNT-1:0][lec_pkg::CNT_W-1:0] cntValue;
   // Pulse on reaching full count
   logic [lec_pkg::NUM_CNT-1:0] cntEvent;

   // Address phase decode
   // One cycle per accepted transfer
   logic takeAccess;
   // Bits above the index ignored
   logic [lec_pkg::IDX_W-1:0] addrIdx;

   // Shared decoding: counter loop,
   // read mux and irq bit order use
   // these, so they cannot disagree

   // Index of one counter inside the flat arrays
   // Slot-major, kind-minor
   function automatic int unsigned cntSlot(
      input int unsigned lane,
      input int unsigned kind
   );
      // Three kinds per slot
      cntSlot = lane * lec_pkg::NUM_KINDS + kind;
   endfunction

   // Three counter values of one lane as a readable word
   // Kind 2 highest, kind 0 lowest
   // Top byte unused, reads zero
   function automatic logic [31:0] laneCounts(
      input logic [lec_pkg::NUM_CNT-1:0][lec_pkg::CNT_W-1:0] values,
      input int unsigned lane
   );
      laneCounts = {8'h00,
         values[cntSlot(lane, lec_pkg::SEL_UNEXPECTED_CTRL)],
         values[cntSlot(lane, lec_pkg::SEL_INVALID_CODE)],
         values[cntSlot(lane, lec_pkg::SEL_DISPARITY)]};
   endfunction

   // Zero-extend an eight-bit register to a bus word
   // Keeps reserved bits at zero
   function automatic logic [31:0] byteWord(
      input logic [lec_pkg::REG_W-1:0] value
   );
      // Upper bytes forced to zero
      byteWord = {24'h00_0000, value};
   endfunction

   // Reset release through two flip-flops
   // Assert at once, release after two
   // edges to avoid a metastable exit
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rs <= '0;
      end else begin
         // Shift a one through both stages
         rs.rstMeta <= 1'b1;
         rs.rstSync <= rs.rstMeta;
      end
   end

   // Synchronised reset used by the whole design
   // Only the second flop drives it
   assign rstSync_n = rs.rstSync;

   // Lane slots in order 0, 6, 7
   // Strobes share this clock,
   // so no synchroniser is needed
   assign errIn[lec_pkg::SLOT_LANE0] = errLane0;
   assign errIn[lec_pkg::SLOT_LANE6] = errLane6;
   assign errIn[lec_pkg::SLOT_LANE7] = errLane7;

   // A valid transfer is taken when selected, active and bus ready
   // Idle and busy types ignored
   assign takeAccess = hsel && hready && htrans[1];

   // Word index from the byte address
   // Byte lanes are not decoded
   assign addrIdx = haddr[lec_pkg::IDX_LSB +: lec_pkg::IDX_W];

   // Each counter reads its own bit of
   // the lane's enable, clear and hold
   // Clear wins over counting; a held
   // counter ignores errors when full
   // Hold changes while errors flow are
   // not guarded; software keeps order

   // One counter per lane and error kind
   for (genvar l = 0; l < lec_pkg::NUM_LANES; l++) begin : g_lane
      for (genvar k = 0; k < lec_pkg::NUM_KINDS; k++) begin : g_kind
         lec_err_counter u_cnt (
            .core_clk(core_clk),
            .rstSync_n(rstSync_n),
            .errPulse(errIn[l][k]),
            // Bit k of each field picks the same counter kind
            .enable(st.ctrl[l][lec_pkg::ENA_LSB + k]),
            .clear(st.ctrl[l][lec_pkg::CLR_LSB + k]),
            .hold(st.hold[l][lec_pkg::HOLD_LSB + k]),
            .count(cntValue[cntSlot(l, k)]),
            .tcEvent(cntEvent[cntSlot(l, k)])
         );
      end
   end

   // Address phase: hsel, htrans and
   // hready sampled; a write latches
   // only its index
   // Data phase: write lands at next
   // edge; read data stands one cycle
   // A read right behind a write to
   // the same word sees the old value
   // Read data is zero with no read

   // Next-state logic for the bus slave and the register bank
   // Every field holds unless a
   // branch below changes it
   always_comb begin
      next_st = st;
      // Slave always ready with an OKAY answer
      // No wait state ever inserted
      next_st.ready = 1'b1;
      next_st.resp = lec_pkg::HRESP_OKAY;

      // Data phase of a write: store the word into its register
      // Index latched a cycle earlier;
      // hwdata is valid only now
      if (st.phase == lec_pkg::PH_WRITE) begin
         unique case (st.wrIdx)
            lec_pkg::IDX_LANE0_CTRL: begin
               next_st.ctrl[lec_pkg::SLOT_LANE0] =
                  hwdata[lec_pkg::REG_W-1:0] & lec_pkg::CTRL_MASK;
            end
            lec_pkg::IDX_LANE6_CTRL: begin
               // Enable and clear fields, reserved bits kept zero
               next_st.ctrl[lec_pkg::SLOT_LANE6] =
                  hwdata[lec_pkg::REG_W-1:0] & lec_pkg::CTRL_MASK;
            end
            lec_pkg::IDX_LANE7_CTRL: begin
               next_st.ctrl[lec_pkg::SLOT_LANE7] =
                  hwdata[lec_pkg::REG_W-1:0] & lec_pkg::CTRL_MASK;
            end
            lec_pkg::IDX_LANE0_HOLD: begin
               // Only the three hold bits are stored
               next_st.hold[lec_pkg::SLOT_LANE0] =
                  hwdata[lec_pkg::REG_W-1:0] & lec_pkg::HOLD_MASK;
            end
            lec_pkg::IDX_LANE6_HOLD: begin
               next_st.hold[lec_pkg::SLOT_LANE6] =
                  hwdata[lec_pkg::REG_W-1:0] & lec_pkg::HOLD_MASK;
            end
            lec_pkg::IDX_LANE7_HOLD: begin
               next_st.hold[lec_pkg::SLOT_LANE7] =
                  hwdata[lec_pkg::REG_W-1:0] & lec_pkg::HOLD_MASK;
            end
            // One mask bit per counter
            lec_pkg::IDX_IRQ_ENABLE: begin
               next_st.irqEnable = hwdata[lec_pkg::NUM_CNT-1:0];
            end
            // Ones clear, zeros keep
            lec_pkg::IDX_IRQ_CLEAR: begin
               // Write one to clear a status bit
               next_st.irqStatus = st.irqStatus
                  & ~hwdata[lec_pkg::NUM_CNT-1:0];
            end
            default: begin
               // Read-only and unmapped words ignore writes
               // and still answer OKAY
            end
         endcase
      end

      // Sticky until software clears;
      // no event is lost to a clear
      // New terminal-count events win over a clear in the same cycle
      next_st.irqStatus = next_st.irqStatus | cntEvent;

      // Address phase: latch writes, prepare read data
      // Reads see registers before
      // a write landing at this edge
      next_st.phase = lec_pkg::PH_IDLE;
      next_st.rdata = lec_pkg::WORD_ZERO;
      if (takeAccess) begin
         if (hwrite) begin
            // Write data follows in the next cycle
            next_st.phase = lec_pkg::PH_WRITE;
            next_st.wrIdx = addrIdx;
         end else begin
            unique case (addrIdx)
               lec_pkg::IDX_LANE0_CTRL: begin
                  next_st.rdata = byteWord(st.ctrl[lec_pkg::SLOT_LANE0]);
               end
               lec_pkg::IDX_LANE6_CTRL: begin
                  // Reserved bits [7:6] read zero
                  next_st.rdata = byteWord(st.ctrl[lec_pkg::SLOT_LANE6]);
               end
               lec_pkg::IDX_LANE7_CTRL: begin
                  next_st.rdata = byteWord(st.ctrl[lec_pkg::SLOT_LANE7]);
               end
               lec_pkg::IDX_LANE0_HOLD: begin
                  // Reserved bits [7:3] read zero
                  next_st.rdata = byteWord(st.hold[lec_pkg::SLOT_LANE0]);
               end
               lec_pkg::IDX_LANE6_HOLD: begin
                  next_st.rdata = byteWord(st.hold[lec_pkg::SLOT_LANE6]);
               end
               lec_pkg::IDX_LANE7_HOLD: begin
                  next_st.rdata = byteWord(st.hold[lec_pkg::SLOT_LANE7]);
               end
               // Count words are read-only
               lec_pkg::IDX_LANE0_COUNT: begin
                  // Live counter values of lane 0
                  next_st.rdata = laneCounts(cntValue, lec_pkg::SLOT_LANE0);
               end
               lec_pkg::IDX_LANE6_COUNT: begin
                  next_st.rdata = laneCounts(cntValue, lec_pkg::SLOT_LANE6);
               end
               lec_pkg::IDX_LANE7_COUNT: begin
                  next_st.rdata = laneCounts(cntValue, lec_pkg::SLOT_LANE7);
               end
               // One status bit per counter
               lec_pkg::IDX_IRQ_STATUS: begin
                  next_st.rdata = {23'h00_0000, st.irqStatus};
               end
               lec_pkg::IDX_IRQ_ENABLE: begin
                  next_st.rdata = {23'h00_0000, st.irqEnable};
               end
               default: begin
                  // Clear register and unmapped words read zero
                  next_st.rdata = lec_pkg::WORD_ZERO;
               end
            endcase
         end
      end

      // Level interrupt while any enabled status bit is set
      // Next values: irq moves with status
      next_st.irq = |(next_st.irqStatus & next_st.irqEnable);
   end

   // State register with its reset values
   // Counters start enabled but held
   // at zero until software lowers
   // the clear bits
   // Hold fields start with stop set
   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         // Enable and clear fields all ones
         st.ctrl <= {lec_pkg::NUM_LANES{lec_pkg::CTRL_RESET}};
         // Hold enabled for all three counters
         st.hold <= {lec_pkg::NUM_LANES{lec_pkg::HOLD_RESET}};
         // Slave idle, ready, OKAY
         st.phase <= lec_pkg::PH_IDLE;
         st.wrIdx <= '0;
         st.rdata <= lec_pkg::WORD_ZERO;
         st.ready <= 1'b1;
         st.resp <= lec_pkg::HRESP_OKAY;
         // Nothing pending, all masked
         st.irqStatus <= lec_pkg::IRQ_NONE;
         st.irqEnable <= lec_pkg::IRQ_NONE;
         st.irq <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // No logic between flop and pin
   // Bus answers and interrupt from flip-flops
   assign hrdata = st.rdata;
   assign hreadyout = st.ready;
   assign hresp = st.resp;
   assign irq = st.irq;

endmodule

`default_nettype wire

// [sim/lec_lane_source.sv]
// Lane transmitter model that raises code error strobes in bursts
`timescale 1ns/1ns
`default_nettype none

module lec_lane_source (
   input wire logic core_clk,
   input wire logic go,
   input wire logic [8:0] sel,
   input wire logic [9:0] len,
   input wire logic slow,
   output logic [2:0] errLane0,
   output logic [2:0] errLane6,
   output logic [2:0] errLane7,
   output logic busy
);
   logic [9:0] left = 10'h000; // Error cycles still to send
   logic gap = 1'b0; // Idle cycle between errors in slow mode
   logic [8:0] act = 9'h000; // Strobes of the running burst

   // Load a burst, then count it down, one error per strobe cycle
   always_ff @(posedge core_clk) begin
      if (go) begin
         left <= len;
         act <= sel;
         gap <= 1'b0;
      end else if (left != 10'h000) begin
         if (!gap) begin
            left <= left - 10'h001;
         end
         gap <= slow & !gap;
      end
   end

   // Bit 2 control char, bit 1 table, bit 0 disparity per lane slot
   assign {errLane7, errLane6, errLane0} =
      (left != 10'h000 && !gap) ? act : 9'h000;
   assign busy = (left != 10'h000);
endmodule

`default_nettype wire

// [sim/lec_top_properties.sv]
// Port-level assertions for the lane error counter register bank
`timescale 1ns/1ns
`default_nettype none

module lec_top_checker (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   logic [11:0] idx; // Word index of the address phase
   logic take; // Transfer accepted at this edge
   logic rdTake; // Read accepted at this edge
   logic wrPh; // Write data phase in progress
   logic [11:0] wrIdx; // Index of the pending write
   logic [7:0] ctrl6; // Expected lane 6 control value
   logic [7:0] hold0; // Expected lane 0 hold value

   assign idx = haddr[13:2];
   assign take = hsel & htrans[1] & hreadyout;
   assign rdTake = take & !hwrite;

   // Mirror two writable registers from the write data phases
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPh <= 1'b0;
         wrIdx <= 12'h000;
         ctrl6 <= lec_pkg::CTRL_RESET;
         hold0 <= lec_pkg::HOLD_RESET;
      end else begin
         wrPh <= take & hwrite;
         wrIdx <= idx;
         if (wrPh && wrIdx == lec_pkg::IDX_LANE6_CTRL) begin
            ctrl6 <= hwdata[7:0] & lec_pkg::CTRL_MASK;
         end
         if (wrPh && wrIdx == lec_pkg::IDX_LANE0_HOLD) begin
            hold0 <= hwdata[7:0] & lec_pkg::HOLD_MASK;
         end
      end
   end

   ctrl6_mirror_a: assert property (
      rdTake && idx == lec_pkg::IDX_LANE6_CTRL
      |=> hrdata == {24'h00_0000, $past(ctrl6)})
      else $error("lane 6 control read differs");
   hold0_mirror_a: assert property (
      rdTake && idx == lec_pkg::IDX_LANE0_HOLD
      |=> hrdata == {24'h00_0000, $past(hold0)})
      else $error("lane 0 hold read differs");
   ctrl7_reserved_a: assert property (
      rdTake && idx == lec_pkg::IDX_LANE7_CTRL |=> hrdata[31:6] == 26'h0)
      else $error("lane 7 control reserved bits set");
   count_width_a: assert property (
      rdTake && idx == lec_pkg::IDX_LANE6_COUNT |=> hrdata[31:24] == 8'h00)
      else $error("count word upper byte set");
   unmapped_zero_a: assert property (
      rdTake && idx[11:8] != 4'h4 |=> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   idle_rdata_a: assert property (
      !rdTake |=> hrdata == 32'h0000_0000)
      else $error("read data without read");
   ready_always_a: assert property (hreadyout[*2])
      else $error("wait state inserted");
   resp_okay_a: assert property (take |-> hresp == 1'b0 ##1 hresp == 1'b0)
      else $error("error response given");

   cover property (wrPh && wrIdx == lec_pkg::IDX_LANE6_CTRL);
   cover property ($rose(irq));
   cover property (rdTake && idx == lec_pkg::IDX_LANE0_COUNT);
endmodule

bind lec_top lec_top_checker i_chk (.core_clk(core_clk),
   .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

`default_nettype wire

// [sim/lec_top_test.sv]
// Self-checking bench for the lane error counter register bank
`timescale 1ns/1ns
`default_nettype none

module lec_top_test;
   logic core_clk = 1'b0; // Bench clock, 100 ns period
   logic reset_n = 1'b0; // Active-low reset
   logic hsel = 1'b0; // Bus master outputs
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = lec_pkg::HSIZE_WORD;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata; // Slave outputs
   logic hreadyout;
   logic hresp;
   logic irq;
   logic [2:0] e0, e6, e7; // Error strobes from the lane model
   logic go = 1'b0; // Lane model controls
   logic [8:0] sel = 9'h000;
   logic [9:0] len = 10'h000;
   logic slow = 1'b0;
   logic busy;
   logic [31:0] rnd = 32'hE0ED_1906; // Random source state
   logic [31:0] rd; // Last read data
   logic [2:0] en; // Enables under test
   logic [9:0] n; // Burst length under test
   int n_mismatch = 0;
   int comparisons = 0;

   always #50 core_clk = ~core_clk;

   lec_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .errLane0(e0),
      .errLane6(e6), .errLane7(e7), .irq(irq));
   lec_lane_source i_src (.core_clk(core_clk), .go(go), .sel(sel),
      .len(len), .slow(slow), .errLane0(e0), .errLane6(e6),
      .errLane7(e7), .busy(busy));

   // Next random word
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected count word: each enabled kind saw every error
   function automatic logic [31:0] cnt_exp(input logic [2:0] e,
         input logic [9:0] k);
      return {8'h00, e[2] ? k[7:0] : 8'h00, e[1] ? k[7:0] : 8'h00,
         e[0] ? k[7:0] : 8'h00};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One single word transfer; read data lands in rd
   task automatic bus(input logic [11:0] ix, input logic wr,
         input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {18'h0_0000, ix, 2'b00};
      htrans <= lec_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      rd = hrdata;
   endtask

   task automatic rdc(input logic [11:0] ix, input logic [31:0] exp);
      bus(ix, 1'b0, 32'h0000_0000);
      check(rd, exp);
      check({31'h0000_0000, hresp}, 32'h0000_0000);
   endtask

   // Send one burst of error strobes and wait for its end
   task automatic burst(input logic [8:0] s, input logic [9:0] k,
         input logic sl);
      go <= 1'b1;
      sel <= s;
      len <= k;
      slow <= sl;
      @(posedge core_clk);
      go <= 1'b0;
      @(posedge core_clk);
      while (busy) @(posedge core_clk);
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Cut a hang short
   initial begin
      repeat (6000) @(posedge core_clk);
      n_mismatch++;
      report_and_stop;
   end

   // Main sequence
   initial begin
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rdc(lec_pkg::IDX_LANE6_CTRL, 32'h0000_003F);
      rdc(lec_pkg::IDX_LANE7_CTRL, 32'h0000_003F);
      rdc(lec_pkg::IDX_LANE0_HOLD, 32'h0000_0007);
      rdc(12'h4A3, 32'h0000_0000);
      rdc(12'h3A3, 32'h0000_0000);
      burst(9'h1FF, 10'h005, 1'b0);
      rdc(lec_pkg::IDX_LANE6_COUNT, 32'h0000_0000);
      $display("test reset values done");
      // Each kind alone, then random enable mixes
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         en = (i < 3) ? (3'h1 << i) : rnd[2:0];
         n = {4'h0, rnd[13:8]} + 10'h001;
         bus(lec_pkg::IDX_LANE6_CTRL, 1'b1, 32'h0000_0007);
         bus(lec_pkg::IDX_LANE6_CTRL, 1'b1, {26'h000_0000, en, 3'h0});
         rdc(lec_pkg::IDX_LANE6_CTRL, {26'h000_0000, en, 3'h0});
         burst(9'h038, n, rnd[16]);
         rdc(lec_pkg::IDX_LANE6_COUNT, cnt_exp(en, n));
      end
      $display("test enables done");
      // Held counter stops at terminal count and raises its event
      bus(lec_pkg::IDX_LANE0_CTRL, 1'b1, 32'h0000_0020);
      burst(9'h004, 10'h12C, 1'b0);
      rdc(lec_pkg::IDX_LANE0_COUNT, 32'h00FF_0000);
      rdc(lec_pkg::IDX_IRQ_STATUS, 32'h0000_0004);
      check({31'h0000_0000, irq}, 32'h0000_0000);
      bus(lec_pkg::IDX_IRQ_ENABLE, 1'b1, 32'h0000_0004);
      repeat (2) @(posedge core_clk);
      check({31'h0000_0000, irq}, 32'h0000_0001);
      bus(lec_pkg::IDX_IRQ_CLEAR, 1'b1, 32'h0000_0004);
      repeat (2) @(posedge core_clk);
      check({31'h0000_0000, irq}, 32'h0000_0000);
      bus(lec_pkg::IDX_LANE0_CTRL, 1'b1, 32'h0000_0024);
      bus(lec_pkg::IDX_LANE0_CTRL, 1'b1, 32'h0000_0020);
      rdc(lec_pkg::IDX_LANE0_COUNT, 32'h0000_0000);
      $display("test hold done");
      // Unheld counter wraps; hold written while no errors flow
      bus(lec_pkg::IDX_LANE7_HOLD, 1'b1, 32'h0000_0000);
      bus(lec_pkg::IDX_LANE0_HOLD, 1'b1, 32'hFFFF_FFFF);
      rdc(lec_pkg::IDX_LANE0_HOLD, 32'h0000_0007);
      bus(lec_pkg::IDX_LANE7_CTRL, 1'b1, 32'h0000_0010);
      burst(9'h080, 10'h102, 1'b1);
      rdc(lec_pkg::IDX_LANE7_COUNT, 32'h0000_0200);
      rdc(lec_pkg::IDX_IRQ_STATUS, 32'h0000_0080);
      $display("test wrap done");
      // Second reset in mid-run
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rdc(lec_pkg::IDX_LANE7_CTRL, 32'h0000_003F);
      $display("test second reset done");
      report_and_stop;
   end
endmodule

`default_nettype wire
